// ===== rtl/usb_status_pkg.sv
// package of constants and types for the usb status and charger signalling block
package usb_status_pkg;

  // ****************************************
  // register offsets (byte addresses, word aligned)
  // ****************************************
  localparam logic [7:0] OFS_CONTROL   = 8'h00;  // control bits
  localparam logic [7:0] OFS_STATUS    = 8'h04;  // live state
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;  // sticky events
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;  // interrupt enables
  localparam logic [7:0] OFS_CHG_MAP   = 8'h10;  // charger code mapping

  // ****************************************
  // control field positions
  // ****************************************
  localparam int CTL_HALF_DUPLEX = 0;  // transmit-enable output in use
  localparam int CTL_LED_ENABLE  = 1;  // activity indicators in use

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0] CTL_RESET     = 2'h0;
  localparam logic [7:0] CHG_MAP_RESET = 8'hE4;  // 11,10,01,00 per type slot
  localparam logic [4:0] MASK_RESET    = 5'h00;

  // ****************************************
  // charger type slots (index into mapping)
  // ****************************************
  localparam logic [1:0] CHG_UNCONFIG = 2'h0;
  localparam logic [1:0] CHG_SDP      = 2'h1;
  localparam logic [1:0] CHG_CDP_DCP  = 2'h2;
  localparam logic [1:0] CHG_SUSPEND  = 2'h3;

  // ****************************************
  // interrupt event bit positions
  // ****************************************
  localparam int EV_VBUS_ON  = 0;
  localparam int EV_VBUS_OFF = 1;
  localparam int EV_DETECT   = 2;
  localparam int EV_WAKE     = 3;
  localparam int EV_SUSPEND  = 4;

  // ****************************************
  // timing: led stretch
  // ****************************************
  localparam int LED_HOLD_NS   = 20000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int LED_HOLD_CYC  = LED_HOLD_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 12;

  // detected port kind from the analogue detector
  typedef enum logic [1:0] {
    PORT_SDP = 2'b00,
    PORT_CDP = 2'b01,
    PORT_DCP = 2'b10
  } port_kind_t;

  // charger detection sequencer states
  typedef enum logic [1:0] {
    DET_IDLE = 2'b00,
    DET_RUN  = 2'b01,
    DET_DONE = 2'b10
  } det_state_t;

  // map a type slot through the mapping register
  function automatic logic [1:0] map_code(input logic [7:0] map, input logic [1:0] slot);
    map_code = map[{slot, 1'b0} +: 2];
  endfunction

endpackage

// ===== rtl/usb_status_evt_if.sv
// interface carrying activity events to the led stretchers
interface usb_status_evt_if;
  logic rx_evt;  // usb receive traffic pulse
  logic tx_evt;  // usb transmit traffic pulse
  logic enable;  // indicators in use
  modport src (output rx_evt, output tx_evt, output enable);
  modport dst (input rx_evt, input tx_evt, input enable);
endinterface

// ===== rtl/usb_activity_led.sv
// activity led stretcher for usb receive and transmit traffic
module usb_activity_led
  import usb_status_pkg::*;
(
  // clock and reset
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst,
  // events
  usb_status_evt_if.dst       evt,
  // leds, active low
  output logic                o_rx_led_n,
  output logic                o_tx_led_n
);

  logic [CNT_W-1:0] rx_cnt;  // receive hold counter
  logic [CNT_W-1:0] tx_cnt;  // transmit hold counter

  // ****************************************
  // stretch counters
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || !evt.enable)
    begin
      rx_cnt <= '0;
      tx_cnt <= '0;
    end
    else
    begin
      // reload on traffic, else count down
      if (evt.rx_evt)
        rx_cnt <= CNT_W'(LED_HOLD_CYC);
      else if (rx_cnt != '0)
        rx_cnt <= rx_cnt - 1'b1;
      if (evt.tx_evt)
        tx_cnt <= CNT_W'(LED_HOLD_CYC);
      else if (tx_cnt != '0)
        tx_cnt <= tx_cnt - 1'b1;
    end
  end

  // ****************************************
  // registered active-low outputs
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rx_led_n <= 1'b1;
      o_tx_led_n <= 1'b1;
    end
    else
    begin
      o_rx_led_n <= !(evt.enable && (evt.rx_evt || rx_cnt != '0));
      o_tx_led_n <= !(evt.enable && (evt.tx_evt || tx_cnt != '0));
    end
  end

endmodule

// ===== rtl/usb_status_charger.sv
// top of the usb status, charger detection and line signalling block
module usb_status_charger
  import usb_status_pkg::*;
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // usb core status
  input  wire logic       i_suspended,
  input  wire logic       i_configured,
  input  wire logic       i_usb_rx_evt,
  input  wire logic       i_usb_tx_evt,
  output logic            o_remote_wakeup,
  // bus power and detector
  input  wire logic       i_vbus_present,
  input  wire logic       i_det_done,
  input  wire logic [1:0] i_det_kind,
  output logic            o_det_start,
  // serial transmitter status
  input  wire logic       i_tx_char_pending,
  input  wire logic       i_tx_shifting,
  // controller side
  input  wire logic       i_wake,
  output logic            o_low_power,
  output logic            o_line_driver_enable,
  output logic            o_charger_type_bit0,
  output logic            o_charger_type_bit1,
  output logic            o_full_speed_plus_line_pullup,
  output logic            o_receive_activity_led_n,
  output logic            o_transmit_activity_led_n,
  output logic            o_irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic [1:0]  ctrl;          // control bits
  logic [7:0]  chg_map;       // charger code mapping
  logic [4:0]  irq_stat;      // sticky events
  logic [4:0]  irq_mask;      // interrupt enables
  logic [4:0]  events;        // this cycle's events
  logic        vbus_q;        // previous bus power level
  logic        susp_q;        // previous suspend level
  logic        wake_q;        // previous wake level
  det_state_t  det_state;     // detection sequencer
  det_state_t  next_det;      // next sequencer state
  port_kind_t  kind;          // latched detected kind
  logic [1:0]  slot;          // current charger type slot
  logic [1:0]  code;          // mapped code
  logic        wake_rise;     // wake edge
  logic        vbus_rise;     // power arrived
  logic        vbus_fall;     // power removed

  usb_status_evt_if evt_bus ();

  assign wake_rise = i_wake && !wake_q;
  assign vbus_rise = i_vbus_present && !vbus_q;
  assign vbus_fall = !i_vbus_present && vbus_q;

  // ****************************************
  // edge history
  // ****************************************
  // one-cycle history of the level inputs; the reset values match the
  // idle level of each pin so no false edge follows reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      vbus_q <= 1'b0;
      susp_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      vbus_q <= i_vbus_present;
      susp_q <= i_suspended;
      wake_q <= i_wake;
    end
  end

  // ****************************************
  // detection sequencer
  // ****************************************
  // a drop of bus power in any state returns the sequencer to idle, so a
  // new attach always starts a fresh detection
  always_comb
  begin
    next_det = det_state;
    case (det_state)
      DET_IDLE:
        if (vbus_rise)
          next_det = DET_RUN;
      DET_RUN:
        if (!i_vbus_present)
          next_det = DET_IDLE;
        else if (i_det_done)
          next_det = DET_DONE;
      DET_DONE:
        if (!i_vbus_present)
          next_det = DET_IDLE;
      default:
        next_det = DET_IDLE;
    endcase
  end

  // state register and latched detector result
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      det_state   <= DET_IDLE;
      kind        <= PORT_SDP;
      o_det_start <= 1'b0;
    end
    else
    begin
      det_state   <= next_det;
      o_det_start <= (det_state == DET_IDLE) && vbus_rise;
      if (det_state == DET_RUN && i_det_done && i_vbus_present)
        kind <= port_kind_t'(i_det_kind);
    end
  end

  // ****************************************
  // charger type code and pull-up
  // ****************************************
  // pick the type slot from sequencer state, link state and latched kind;
  // losing bus power forces the no-charger slot at once, so the code
  // outputs fall on the same edge as the pull-up instead of one later
  always_comb
  begin
    // no finished detection, or power just gone: report no charger
    if (det_state != DET_DONE || !i_vbus_present)
      slot = CHG_UNCONFIG;
    else if (i_suspended)
      slot = CHG_SUSPEND;
    else if (kind == PORT_SDP && !i_configured)
      slot = CHG_UNCONFIG;
    else if (kind == PORT_SDP)
      slot = CHG_SDP;
    else
      slot = CHG_CDP_DCP;
    code = map_code(chg_map, slot);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_charger_type_bit0           <= 1'b0;
      o_charger_type_bit1           <= 1'b0;
      o_full_speed_plus_line_pullup <= 1'b0;
    end
    else
    begin
      o_charger_type_bit0 <= code[0];
      o_charger_type_bit1 <= code[1];
      // dedicated charger never gets the pull-up; the pull-up stays off
      // while detection runs so the host does not see an attach early,
      // and it comes up on the same edge as the charger type code
      o_full_speed_plus_line_pullup <= (next_det == DET_DONE) && (kind != PORT_DCP)
                                       && !(det_state == DET_RUN);
    end
  end

  // ****************************************
  // low power and wakeup
  // ****************************************
  // low-power level follows the link state with one cycle of lag; the
  // wakeup request is a single-cycle pulse on a wake edge while suspended
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_low_power     <= 1'b1;
      o_remote_wakeup <= 1'b0;
    end
    else
    begin
      o_low_power     <= i_suspended || !i_configured;
      o_remote_wakeup <= wake_rise && i_suspended;
    end
  end

  // ****************************************
  // half-duplex line driver enable
  // ****************************************
  // the shifter-busy input covers the stop bits of the last character, so
  // the driver is released only once the line has gone back to idle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_line_driver_enable <= 1'b0;
    else
      o_line_driver_enable <= ctrl[CTL_HALF_DUPLEX]
                              && (i_tx_char_pending || i_tx_shifting);
  end

  // ****************************************
  // activity leds
  // ****************************************
  // the stretcher keeps short traffic pulses visible to the eye
  assign evt_bus.rx_evt = i_usb_rx_evt;
  assign evt_bus.tx_evt = i_usb_tx_evt;
  assign evt_bus.enable = ctrl[CTL_LED_ENABLE];

  usb_activity_led u_led (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .evt        (evt_bus),
    .o_rx_led_n (o_receive_activity_led_n),
    .o_tx_led_n (o_transmit_activity_led_n)
  );

  // ****************************************
  // interrupt events
  // ****************************************
  // one-cycle event pulses; each is caught by the sticky status below
  always_comb
  begin
    events              = '0;
    events[EV_VBUS_ON]  = vbus_rise;
    events[EV_VBUS_OFF] = vbus_fall;
    events[EV_DETECT]   = (det_state == DET_RUN) && (next_det == DET_DONE);
    events[EV_WAKE]     = wake_rise;
    events[EV_SUSPEND]  = i_suspended && !susp_q;
  end

  // ****************************************
  // register writes and sticky status
  // ****************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ctrl     <= CTL_RESET;
      chg_map  <= CHG_MAP_RESET;
      irq_mask <= MASK_RESET;
      irq_stat <= '0;
    end
    else
    begin
      // set wins over write-one-to-clear
      if (i_wr && i_addr == OFS_IRQ_STAT)
        irq_stat <= (irq_stat & ~i_wdata[4:0]) | events;
      else
        irq_stat <= irq_stat | events;
      if (i_wr && i_addr == OFS_CONTROL)
        ctrl <= i_wdata[1:0];
      else if (i_wr && i_addr == OFS_IRQ_MASK)
        irq_mask <= i_wdata[4:0];
      else if (i_wr && i_addr == OFS_CHG_MAP)
        chg_map <= i_wdata;
    end
  end

  // ****************************************
  // register reads and interrupt output
  // ****************************************
  // read data stand for one cycle after the strobe and are zero otherwise,
  // so a stale value never lingers on the bus
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= '0;
      o_irq   <= 1'b0;
    end
    else
    begin
      o_irq <= |(irq_stat & irq_mask);
      if (!i_rd)
        o_rdata <= '0;
      else if (i_addr == OFS_CONTROL)
        o_rdata <= {6'h00, ctrl};
      else if (i_addr == OFS_STATUS)
        o_rdata <= {kind, det_state, o_full_speed_plus_line_pullup, code, i_vbus_present};
      else if (i_addr == OFS_IRQ_STAT)
        o_rdata <= {3'h0, irq_stat};
      else if (i_addr == OFS_IRQ_MASK)
        o_rdata <= {3'h0, irq_mask};
      else if (i_addr == OFS_CHG_MAP)
        o_rdata <= chg_map;
      else
        o_rdata <= 8'h00;  // unmapped reads zero
    end
  end

endmodule

// ===== testbench/usb_status_charger_properties.sv
// port-level assertions for the usb status and charger block
module usb_status_charger_properties
  import usb_status_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_suspended,
  input wire logic       i_configured,
  input wire logic       i_wake,
  input wire logic       i_vbus_present,
  input wire logic       i_det_done,
  input wire logic [1:0] i_det_kind,
  input wire logic       i_tx_char_pending,
  input wire logic       i_tx_shifting,
  input wire logic       i_usb_rx_evt,
  input wire logic       i_usb_tx_evt,
  input wire logic       o_low_power,
  input wire logic       o_line_driver_enable,
  input wire logic       o_remote_wakeup,
  input wire logic       o_det_start,
  input wire logic       o_full_speed_plus_line_pullup,
  input wire logic       o_charger_type_bit0,
  input wire logic       o_charger_type_bit1,
  input wire logic       o_receive_activity_led_n,
  input wire logic       o_transmit_activity_led_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  low_power_a: assert property (!$past(i_rst) |-> o_low_power == ($past(i_suspended) || !$past(i_configured)))
    else $error("low power output wrong");
  drv_cause_a: assert property (o_line_driver_enable |-> $past(i_tx_char_pending) || $past(i_tx_shifting))
    else $error("line driver on with nothing to send");
  wake_req_a: assert property ($rose(i_wake) && i_suspended |=> o_remote_wakeup)
    else $error("wake not forwarded");
  wake_cause_a: assert property (o_remote_wakeup |-> $past(i_wake) && $past(i_suspended))
    else $error("wakeup without cause");
  det_start_a: assert property ($rose(i_vbus_present) |=> o_det_start)
    else $error("detection not started");
  vbus_off_a: assert property (!$past(i_vbus_present) |-> !o_full_speed_plus_line_pullup
    && !o_charger_type_bit0 && !o_charger_type_bit1)
    else $error("outputs not cleared without power");
  pullup_on_a: assert property ((i_det_done && i_vbus_present && i_det_kind != PORT_DCP) ##1 i_vbus_present
    |=> o_full_speed_plus_line_pullup)
    else $error("pull-up not enabled");
  pullup_dcp_a: assert property ((i_det_done && i_det_kind == PORT_DCP) |=> ##1 !o_full_speed_plus_line_pullup)
    else $error("pull-up on for dedicated charger");
  rx_led_a: assert property ($fell(o_receive_activity_led_n) |-> $past(i_usb_rx_evt))
    else $error("receive led without traffic");
  tx_led_a: assert property ($fell(o_transmit_activity_led_n) |-> $past(i_usb_tx_evt))
    else $error("transmit led without traffic");

  cover property (o_remote_wakeup);
  cover property (o_det_start);
  cover property (!o_receive_activity_led_n && !o_transmit_activity_led_n);
endmodule

bind usb_status_charger usb_status_charger_properties u_props (.i_ref_clk, .i_rst, .i_suspended,
  .i_configured, .i_wake, .i_vbus_present, .i_det_done, .i_det_kind, .i_tx_char_pending,
  .i_tx_shifting, .i_usb_rx_evt, .i_usb_tx_evt, .o_low_power, .o_line_driver_enable,
  .o_remote_wakeup, .o_det_start, .o_full_speed_plus_line_pullup, .o_charger_type_bit0,
  .o_charger_type_bit1, .o_receive_activity_led_n, .o_transmit_activity_led_n);

// ===== testbench/charger_detector_model.sv
// charger detector model answering each start pulse after a chosen delay
module charger_detector_model
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_start,
  input  wire logic [1:0] i_kind_sel,
  input  wire logic [3:0] i_delay,
  output logic            o_done,
  output logic      [1:0] o_kind
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt = 5'h00;  // cycles left in a running detection
  // one done pulse per start, prompt or slow as the delay says
  always @(posedge i_ref_clk)
  begin
    o_done <= (cnt == 5'h01);
    if (i_start) cnt <= {1'b0, i_delay} + 5'h01;
    else if (cnt != 5'h00) cnt <= cnt - 5'h01;
  end
  // kind is only meaningful beside done, garbage otherwise
  assign o_kind = o_done ? i_kind_sel : ~i_kind_sel;
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the usb status and charger block
module tb_top
  import usb_status_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, pins;
  logic       i_suspended = 1'b0, i_configured = 1'b0, i_usb_rx_evt = 1'b0, i_usb_tx_evt = 1'b0;
  logic       i_vbus_present = 1'b0, i_tx_char_pending = 1'b0, i_tx_shifting = 1'b0, i_wake = 1'b0;
  logic       i_det_done, o_remote_wakeup, o_det_start, o_low_power, o_line_driver_enable, o_irq;
  logic       o_charger_type_bit0, o_charger_type_bit1, o_full_speed_plus_line_pullup;
  logic       o_receive_activity_led_n, o_transmit_activity_led_n;
  logic [1:0] i_det_kind, kind_sel = 2'h0;
  logic [3:0] dly = 4'h0;
  logic [7:0] exp_det [3] = '{8'h74, 8'h78, 8'h68};  // sdp, cdp, dcp
  int         err_total = 0, check_count = 0;

  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  // outputs gathered: irq, tx led, rx led, pull-up, code, driver enable, low power
  assign pins = {o_irq, o_transmit_activity_led_n, o_receive_activity_led_n, o_full_speed_plus_line_pullup,
                 o_charger_type_bit1, o_charger_type_bit0, o_line_driver_enable, o_low_power};

  usb_status_charger u_dut (.i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_suspended,
    .i_configured, .i_usb_rx_evt, .i_usb_tx_evt, .o_remote_wakeup, .i_vbus_present, .i_det_done,
    .i_det_kind, .o_det_start, .i_tx_char_pending, .i_tx_shifting, .i_wake, .o_low_power,
    .o_line_driver_enable, .o_charger_type_bit0, .o_charger_type_bit1, .o_full_speed_plus_line_pullup,
    .o_receive_activity_led_n, .o_transmit_activity_led_n, .o_irq);
  charger_detector_model u_partner (.i_ref_clk, .i_start(o_det_start), .i_kind_sel(kind_sel),
    .i_delay(dly), .o_done(i_det_done), .o_kind(i_det_kind));

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // settle two edges, compare the gathered pins, return on an edge
  task automatic see(input logic [7:0] e);
    cyc(2);
    #1 chk("pins", pins, e);
    @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", o_rdata, e);
    @(posedge i_ref_clk);
  endtask
  // one-cycle pulse: 0 receive traffic, 1 transmit traffic, 2 wake
  task automatic pulse(input int sel);
    if (sel == 0) i_usb_rx_evt <= 1'b1;
    else if (sel == 1) i_usb_tx_evt <= 1'b1;
    else i_wake <= 1'b1;
    @(posedge i_ref_clk);
    i_usb_rx_evt <= 1'b0;
    i_usb_tx_evt <= 1'b0;
    i_wake <= 1'b0;
  endtask

  // watchdog cuts a hang short
  initial
  begin
    #200000;
    err_total++;
    give_verdict();
  end

  initial
  begin
    cyc(5);
    #1 chk("pins", pins, 8'h61);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(OFS_CONTROL, 8'h00);
    rd(OFS_IRQ_MASK, 8'h00);
    rd(OFS_CHG_MAP, 8'hE4);
    rd(8'hFC, 8'h00);
    i_configured <= 1'b1;
    see(8'h60);
    i_suspended <= 1'b1;
    see(8'h61);
    i_suspended <= 1'b0;
    wr(OFS_CONTROL, 8'h02);
    i_tx_char_pending <= 1'b1;
    see(8'h60);
    wr(OFS_CONTROL, 8'h03);
    rd(OFS_CONTROL, 8'h03);
    see(8'h62);
    i_tx_char_pending <= 1'b0; i_tx_shifting <= 1'b1;
    see(8'h62);
    i_tx_shifting <= 1'b0;
    see(8'h60);
    pulse(0);
    see(8'h40);
    pulse(1);
    see(8'h00);
    cyc(LED_HOLD_CYC);
    see(8'h60);
    wr(OFS_CONTROL, 8'h01);
    pulse(0);
    see(8'h60);
    for (int k = 0; k < 3; k++)
    begin
      kind_sel <= 2'(k); dly <= 4'(k * 5);
      i_vbus_present <= 1'b1;
      cyc(1);
      #1 chk("start", {7'h00, o_det_start}, 8'h01);
      chk("pins", pins, 8'h60);
      cyc(20);
      see(exp_det[k]);
      i_vbus_present <= 1'b0;
      see(8'h60);
    end
    kind_sel <= 2'(PORT_SDP);
    i_vbus_present <= 1'b1;
    cyc(20);
    i_suspended <= 1'b1;
    see(8'h7D);
    i_suspended <= 1'b0;
    wr(OFS_CHG_MAP, 8'h1B);
    see(8'h78);
    i_configured <= 1'b0;
    see(8'h7D);
    i_configured <= 1'b1;
    wr(OFS_CHG_MAP, 8'hE4);
    i_vbus_present <= 1'b0;
    see(8'h60);
    wr(OFS_IRQ_STAT, 8'h1F);
    wr(OFS_IRQ_MASK, 8'h08);
    pulse(2);
    #1 chk("wakeup", {7'h00, o_remote_wakeup}, 8'h00);
    i_suspended <= 1'b1;
    see(8'hE1);
    i_wake <= 1'b1;
    cyc(1);
    #1 chk("wakeup", {7'h00, o_remote_wakeup}, 8'h01);
    @(posedge i_ref_clk);
    i_wake <= 1'b0;
    #1 chk("wakeup", {7'h00, o_remote_wakeup}, 8'h00);
    rd(OFS_IRQ_STAT, 8'h18);
    see(8'hE1);
    wr(OFS_IRQ_STAT, 8'h08);
    rd(OFS_IRQ_STAT, 8'h10);
    see(8'h61);
    wr(OFS_IRQ_MASK, 8'h10);
    see(8'hE1);
    wr(OFS_IRQ_MASK, 8'h00);
    see(8'h61);
    give_verdict();
  end
endmodule
